/* File: hdl/bpm_regs.sv */
// bpm_regs.sv - power management capability and control/status words
// of the bridge function, reached over the configuration access port.
// assumes: straps steady during operation; one access port, 16-bit
// words at byte offsets; reads answered one cycle later.
//
// Contract
// - high strap set: no power states claimed
// - wake support field reads all zeros
// - d2 support bit follows low strap
// - d1 support bit follows low strap
// - capability bits eight to six zero
// - special initialization flag reads zero
// - aux power and wake clock bits zero
// - version field from low strap
// - d3hot to d0 resets, keeps control word
// - wake status and enable read zero
// - data scale and select read zero
// - control bits seven to two zero
// - power state field readable and writable
// - strap set stops secondary clocks in d3hot
`timescale 1ns/1ps
`include "bpm_consts.svh"
module bpm_regs (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [1:0] cfg_be,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic mode_strap_low_bit,
   input wire logic mode_strap_high_bit,
   input wire logic bus_power_clock_strap,
   output logic [1:0] power_state,
   output logic internal_reset,
   output logic sec_clk_run
);

   // decode a byte offset into the word it selects
   function automatic bpm_pkg::bpm_sel_t dec_sel(input logic [7:0] a);
      if (a == `BPM_OFS_CAP)
         return bpm_pkg::BPM_SEL_CAP;
      else if (a == `BPM_OFS_CSR)
         return bpm_pkg::BPM_SEL_CSR;
      else
         return bpm_pkg::BPM_SEL_NONE;
   endfunction

   // capability word built from the straps alone
   function automatic logic [15:0] cap_word(input logic ms0,
                                            input logic ms1);
      logic [15:0] w;
      w = 16'h0000;
      // d1/d2 only with low strap clear and states supported at all
      w[`BPM_CAP_D2_BIT] = !ms0 && !ms1;
      w[`BPM_CAP_D1_BIT] = !ms0 && !ms1;
      w[`BPM_CAP_VER_HI:`BPM_CAP_VER_LO] =
         ms0 ? `BPM_VER_R10 : `BPM_VER_R11;
      return w;
   endfunction

   // may the power state field take this code under these straps
   function automatic logic ps_legal(input bpm_pkg::bpm_pstate_t s,
                                     input logic ms0, input logic ms1);
      logic ok;
      ok = 1'b1;
      if (ms1)
         ok = (s == bpm_pkg::BPM_D0);
      else if (ms0)
         ok = (s != bpm_pkg::BPM_D1) && (s != bpm_pkg::BPM_D2);
      return ok;
   endfunction

   bpm_pm_if pm (); // link to the state keeper
   bpm_pkg::bpm_sel_t wsel; // word hit by the current write
   bpm_pkg::bpm_sel_t rsel; // word hit by the current read
   bpm_pkg::bpm_pstate_t wstate; // state code carried by the write
   logic [15:0] rdata_r; // read answer
   logic [15:0] rdata_nxt;
   logic rvalid_r; // read answer strobe
   logic rvalid_nxt;

   assign wsel = dec_sel(cfg_addr);
   assign rsel = dec_sel(cfg_addr);
   assign wstate = bpm_pkg::bpm_pstate_t'(
      cfg_wdata[`BPM_CSR_PS_HI:`BPM_CSR_PS_LO]);

   // write path: only the state field of the control word is writable;
   // the capability word and every other bit ignore writes
   always_comb begin
      pm.ps_wr = cfg_wr && (wsel == bpm_pkg::BPM_SEL_CSR) &&
                 cfg_be[0] &&
                 ps_legal(wstate, mode_strap_low_bit,
                          mode_strap_high_bit);
      pm.ps_wdata = wstate;
      pm.clk_ctl_en = bus_power_clock_strap;
   end

   // state keeper instance
   bpm_state_ctl u_ctl (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pm(pm.ctl)
   );

   // read path: answer next cycle, unmapped offsets read zero
   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = cfg_rd;
      if (cfg_rd) begin
         unique case (rsel)
            bpm_pkg::BPM_SEL_CAP:
               rdata_nxt = cap_word(mode_strap_low_bit,
                                    mode_strap_high_bit);
            bpm_pkg::BPM_SEL_CSR: begin
               // upper fourteen bits fixed at zero
               rdata_nxt = `BPM_CSR_RST;
               rdata_nxt[`BPM_CSR_PS_HI:`BPM_CSR_PS_LO] =
                  pm.ps_state;
            end
            bpm_pkg::BPM_SEL_NONE:
               rdata_nxt = 16'h0000;
            default:
               rdata_nxt = 16'h0000; // unused select code
         endcase
      end
   end

   // read registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_r <= 16'h0000;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // outputs
   assign cfg_rdata = rdata_r;
   assign cfg_rvalid = rvalid_r;
   assign power_state = pm.ps_state;
   assign internal_reset = pm.int_rst;
   assign sec_clk_run = pm.clk_run;

   // checks on the design's own outputs
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   logic rd_cap; // read of the capability word
   logic rd_csr; // read of the control word
   assign rd_cap = cfg_rd && (rsel == bpm_pkg::BPM_SEL_CAP);
   assign rd_csr = cfg_rd && (rsel == bpm_pkg::BPM_SEL_CSR);

   a_cap_no_states: assert property (
      rd_cap && mode_strap_high_bit |=> cfg_rvalid &&
      (cfg_rdata[10:9] == 2'h0))
      else $error("states claimed with high strap set");

   a_cap_wake_zero: assert property (
      rd_cap |=> cfg_rdata[15:11] == 5'h00)
      else $error("wake support field not zero");

   a_cap_d2_bit: assert property (
      rd_cap && !mode_strap_high_bit |=>
      cfg_rdata[10] == !$past(mode_strap_low_bit))
      else $error("d2 support bit wrong");

   a_cap_d1_bit: assert property (
      rd_cap && !mode_strap_high_bit |=>
      cfg_rdata[9] == !$past(mode_strap_low_bit))
      else $error("d1 support bit wrong");

   a_cap_resv_zero: assert property (
      rd_cap |=> cfg_rdata[8:6] == 3'h0)
      else $error("capability reserved bits set");

   a_cap_init_zero: assert property (
      rd_cap |=> !cfg_rdata[5])
      else $error("special init flag set");

   a_cap_aux_zero: assert property (
      rd_cap |=> cfg_rdata[4:3] == 2'h0)
      else $error("aux power or wake clock bit set");

   a_cap_version: assert property (
      rd_cap |=> cfg_rdata[2:0] ==
      ($past(mode_strap_low_bit) ? 3'h1 : 3'h2))
      else $error("version field wrong");

   a_int_rst_d3: assert property (
      pm.ps_wr && (pm.ps_wdata == bpm_pkg::BPM_D0) &&
      (power_state == 2'h3) |=> internal_reset &&
      (power_state == 2'h0) ##1 !internal_reset &&
      (power_state == 2'h0))
      else $error("internal reset missing or state disturbed");

   a_csr_wake_zero: assert property (
      rd_csr |=> !cfg_rdata[15] && !cfg_rdata[8])
      else $error("wake status or enable set");

   a_csr_data_zero: assert property (
      rd_csr |=> cfg_rdata[14:9] == 6'h00)
      else $error("data scale or select not zero");

   a_csr_resv_zero: assert property (
      rd_csr |=> cfg_rdata[7:2] == 6'h00)
      else $error("control reserved bits set");

   a_ps_write: assert property (
      pm.ps_wr ##1 rd_csr |=> cfg_rdata[1:0] == $past(pm.ps_wdata, 2))
      else $error("state readback differs from written value");

   a_clk_stop: assert property (
      sec_clk_run == !(bus_power_clock_strap && (power_state == 2'h3)))
      else $error("secondary clock gating wrong");

   a_ro_ignored: assert property (
      cfg_wr && (wsel != bpm_pkg::BPM_SEL_CSR) |=> $stable(power_state))
      else $error("write outside state field changed state");

   c_d3_exit: cover property (
      power_state == 2'h3 ##1 internal_reset);
   c_cap_read: cover property (rd_cap ##1 cfg_rvalid);
   c_clk_stop: cover property (!sec_clk_run ##[1:8] sec_clk_run);

endmodule // bpm_regs

/* File: common/bpm_consts.svh */
// bpm_consts.svh - offsets, field positions, codes and reset values
// for the bridge power management register pair.
// assumes: included by bare name from common/; holds definitions only.
`ifndef BPM_CONSTS_SVH
`define BPM_CONSTS_SVH

// configuration space byte offsets of the two words
`define BPM_OFS_CAP 8'hde
`define BPM_OFS_CSR 8'he0

// capability word field positions
`define BPM_CAP_WAKE_HI 15
`define BPM_CAP_WAKE_LO 11
`define BPM_CAP_D2_BIT 10
`define BPM_CAP_D1_BIT 9
`define BPM_CAP_VER_HI 2
`define BPM_CAP_VER_LO 0

// revision codes reported in the version field
`define BPM_VER_R10 3'h1
`define BPM_VER_R11 3'h2

// control/status word: power state field and reset value
`define BPM_CSR_PS_HI 1
`define BPM_CSR_PS_LO 0
`define BPM_CSR_RST 16'h0000

`endif

/* File: common/bpm_pkg.sv */
// bpm_pkg.sv - types shared by the power management register block.
// assumes: compiled before the interface and the design modules.
package bpm_pkg;

   // power state field codes as software sees them
   typedef enum logic [1:0] {
      BPM_D0 = 2'h0,
      BPM_D1 = 2'h1,
      BPM_D2 = 2'h2,
      BPM_D3HOT = 2'h3
   } bpm_pstate_t;

   // which word a configuration access hits
   typedef enum logic [1:0] {
      BPM_SEL_NONE = 2'h0,
      BPM_SEL_CAP = 2'h1,
      BPM_SEL_CSR = 2'h3
   } bpm_sel_t;

endpackage

/* File: common/bpm_pm_if.sv */
// bpm_pm_if.sv - link between the register decode and the state keeper.
// assumes: one clock; all signals synchronous to sys_clk.
`timescale 1ns/1ps
interface bpm_pm_if;
   logic ps_wr; // accepted, legal write of the power state field
   bpm_pkg::bpm_pstate_t ps_wdata; // new power state
   logic clk_ctl_en; // bus power/clock control strap level
   bpm_pkg::bpm_pstate_t ps_state; // current power state
   logic int_rst; // one-cycle internal reset on a d3hot to d0 write
   logic clk_run; // secondary clocks allowed to run

   modport regs (output ps_wr, ps_wdata, clk_ctl_en,
                 input ps_state, int_rst, clk_run);
   modport ctl (input ps_wr, ps_wdata, clk_ctl_en,
                output ps_state, int_rst, clk_run);
endinterface

/* File: hdl/bpm_state_ctl.sv */
// bpm_state_ctl.sv - keeps the power state, raises the internal reset
// on d3hot to d0 and gates the secondary clocks.
// assumes: writes arrive already checked for legality.
`timescale 1ns/1ps
module bpm_state_ctl (
   input wire logic sys_clk,
   input wire logic rst_n,
   bpm_pm_if.ctl pm
);

   bpm_pkg::bpm_pstate_t state_r; // current power state
   bpm_pkg::bpm_pstate_t state_nxt;
   logic irst_r; // internal reset pulse
   logic irst_nxt;

   // next state: write takes the new state, d3hot to d0 pulses reset
   always_comb begin
      state_nxt = state_r;
      irst_nxt = 1'b0;
      if (pm.ps_wr) begin
         state_nxt = pm.ps_wdata;
         // internal reset leaves the state field itself alone
         irst_nxt = (state_r == bpm_pkg::BPM_D3HOT) &&
                    (pm.ps_wdata == bpm_pkg::BPM_D0);
      end
   end

   // registers; only the primary reset clears the state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r <= bpm_pkg::BPM_D0;
         irst_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         irst_r <= irst_nxt;
      end
   end

   assign pm.ps_state = state_r;
   assign pm.int_rst = irst_r;
   // clocks stop only in d3hot and only with the strap set
   assign pm.clk_run = !(pm.clk_ctl_en &&
                         (state_r == bpm_pkg::BPM_D3HOT));

endmodule // bpm_state_ctl

/* File: testbench/bpm_regs_tb.sv */
// bpm_regs_tb.sv - self-checking bench for the power management words.
// assumes: bpm_regs with one clock, synchronous reset and the access port.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("unexpected at %0t: got %h want %h", \
   $time, g, e); end end
module bpm_regs_tb;
   // one table row: straps, write, expected state
   typedef struct packed {
      logic lo; // low mode strap
      logic hi; // high mode strap
      logic bpc; // bus power clock strap
      logic [1:0] be; // byte enables
      logic [15:0] wd; // written control word
      logic [1:0] ps; // state expected after the write
   } bpm_row_t;
   logic sys_clk = 1'h0; // 200 mhz clock
   logic rst_n = 1'h0; // active low reset
   logic [7:0] cfg_addr = 8'h00; // access offset
   logic cfg_rd = 1'h0; // read strobe
   logic cfg_wr = 1'h0; // write strobe
   logic [1:0] cfg_be = 2'h0; // byte enables
   logic [15:0] cfg_wdata = 16'h0000; // write data
   logic [15:0] cfg_rdata; // read data
   logic cfg_rvalid; // read answer strobe
   logic ms_lo = 1'h0; // low mode strap
   logic ms_hi = 1'h0; // high mode strap
   logic bpc = 1'h0; // bus power clock strap
   logic [1:0] power_state; // current state
   logic internal_reset; // pulse on d3hot to d0
   logic sec_clk_run; // secondary clocks running
   int n_mismatch = 0; // mismatches seen
   int num_checks = 0; // comparisons made
   bpm_row_t rows [10] = '{
      '{1'h0, 1'h0, 1'h0, 2'h3, 16'h0001, 2'h1},
      '{1'h0, 1'h0, 1'h0, 2'h3, 16'h0002, 2'h2},
      '{1'h0, 1'h0, 1'h1, 2'h3, 16'hffff, 2'h3},
      '{1'h0, 1'h0, 1'h0, 2'h1, 16'h0003, 2'h3},
      '{1'h0, 1'h0, 1'h0, 2'h2, 16'h0002, 2'h0},
      '{1'h1, 1'h0, 1'h0, 2'h3, 16'h0001, 2'h0},
      '{1'h1, 1'h0, 1'h0, 2'h3, 16'h0002, 2'h0},
      '{1'h1, 1'h0, 1'h1, 2'h3, 16'h0003, 2'h3},
      '{1'h0, 1'h1, 1'h0, 2'h3, 16'h0003, 2'h0},
      '{1'h1, 1'h1, 1'h1, 2'h3, 16'h0001, 2'h0}};

   // clock: invert each half period
   always #2.5 sys_clk = ~sys_clk;

   bpm_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_addr(cfg_addr),
      .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .mode_strap_low_bit(ms_lo),
      .mode_strap_high_bit(ms_hi), .bus_power_clock_strap(bpc),
      .power_state(power_state), .internal_reset(internal_reset),
      .sec_clk_run(sec_clk_run));

   // expected capability word from the two mode straps
   function automatic logic [15:0] exp_cap(input logic lo, input logic hi);
      logic s;
      s = ~lo & ~hi;
      return {5'h00, s, s, 6'h00, lo ? 3'h1 : 3'h2};
   endfunction

   // one idle cycle, inputs change just after the edge
   task automatic tick();
      @(posedge sys_clk) #1;
   endtask

   // one read; answer checked the cycle after, strobe gone after that
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      cfg_rd = 1'h1;
      cfg_addr = a;
      tick();
      cfg_rd = 1'h0;
      `CHK(cfg_rvalid, 1'h1)
      `CHK(cfg_rdata, e)
      tick();
      `CHK(cfg_rvalid, 1'h0)
   endtask

   // one write pulse; caller must let an edge pass before the next
   task automatic wr(input logic [7:0] a, input logic [1:0] b,
                     input logic [15:0] d);
      cfg_wr = 1'h1;
      cfg_addr = a;
      cfg_be = b;
      cfg_wdata = d;
      tick();
      cfg_wr = 1'h0;
   endtask

   // closing: counts, then verdict
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watchdog: whole run is well under this span
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end

   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK(power_state, 2'h0)
      `CHK(cfg_rvalid, 1'h0)
      `CHK(sec_clk_run, 1'h1)
      `CHK(internal_reset, 1'h0)
      rst_n = 1'h1;
      tick();
      rd(8'he0, 16'h0000);
      $display("test reset done");
      // table: straps, state writes, read-only writes, readback
      foreach (rows[i]) begin
         ms_lo = rows[i].lo;
         ms_hi = rows[i].hi;
         bpc = rows[i].bpc;
         wr(8'he0, 2'h3, 16'h0000);
         tick();
         wr(8'hde, 2'h3, 16'hffff);
         tick();
         wr(8'he0, rows[i].be, rows[i].wd);
         `CHK(power_state, rows[i].ps)
         `CHK(sec_clk_run, ~(bpc & (rows[i].ps == 2'h3)))
         tick();
         rd(8'hde, exp_cap(ms_lo, ms_hi));
         rd(8'hde, exp_cap(ms_lo, ms_hi));
         rd(8'he0, {14'h0000, rows[i].ps});
         rd(8'he0, {14'h0000, rows[i].ps});
      end
      $display("test table done");
      // d3hot to d0 pulses the internal reset, word kept
      {ms_lo, ms_hi, bpc} = 3'h0;
      wr(8'he0, 2'h3, 16'h0003);
      tick();
      `CHK(internal_reset, 1'h0)
      wr(8'he0, 2'h3, 16'h0000);
      `CHK(internal_reset, 1'h1)
      tick();
      `CHK(internal_reset, 1'h0)
      rd(8'he0, 16'h0000);
      wr(8'he0, 2'h3, 16'h0002);
      rd(8'he0, 16'h0002);
      wr(8'he0, 2'h3, 16'h0000);
      `CHK(internal_reset, 1'h0)
      tick();
      $display("test internal reset done");
      // unmapped offset: reads zero, write has no effect
      rd(8'h10, 16'h0000);
      wr(8'h10, 2'h3, 16'h0003);
      tick();
      `CHK(power_state, 2'h0)
      // back-to-back reads with the strobe held
      cfg_rd = 1'h1;
      cfg_addr = 8'hde;
      tick();
      cfg_addr = 8'he0;
      `CHK(cfg_rdata, 16'h0602)
      tick();
      cfg_rd = 1'h0;
      `CHK(cfg_rvalid, 1'h1)
      `CHK(cfg_rdata, 16'h0000)
      tick();
      $display("test unmapped and back to back done");
      // reset in mid-run returns the word to its reset value
      wr(8'he0, 2'h3, 16'h0002);
      tick();
      rst_n = 1'h0;
      tick();
      rst_n = 1'h1;
      `CHK(power_state, 2'h0)
      tick();
      rd(8'he0, 16'h0000);
      $display("test second reset done");
      finish_test();
   end
endmodule // bpm_regs_tb
